//--- pkg/lcr_pkg.sv
package lcr_pkg;
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h1F;
   localparam int ADDR_SEL_BIT = 1;
   localparam int CONT_BIT = 7;
   localparam logic [1:0] OP_MODE_SET = 2'h2;
   localparam logic [1:0] OP_LOAD_PTR = 2'h0;
   localparam logic [3:0] OP_DEV_SEL = 4'hC;
   localparam logic [4:0] OP_BANK_SEL = 5'h1E;
   localparam logic [3:0] OP_BLINK = 4'hE;
   localparam int MS_POWER_BIT = 4;
   localparam int MS_ENABLE_BIT = 3;
   localparam int MS_BIAS_BIT = 2;
   localparam logic [1:0] DRIVE_STATIC = 2'h1;
   localparam logic [1:0] DRIVE_MUX2 = 2'h2;
   localparam logic [1:0] DRIVE_MUX3 = 2'h3;
   localparam logic [1:0] DRIVE_MUX4 = 2'h0;
   localparam logic [4:0] STEP_STATIC = 5'h08;
   localparam logic [4:0] STEP_MUX2 = 5'h04;
   localparam logic [4:0] STEP_MUX3 = 5'h03;
   localparam logic [4:0] STEP_MUX4 = 5'h02;
   localparam logic [4:0] RAM_WORDS = 5'h18;
   localparam logic [1:0] RST_DRIVE = 2'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam int BUF_DEPTH = 2;
   localparam int BUF_WIDTH = 13;
endpackage

//--- rtl/lcr_buf.sv
// Two-entry buffer; in power saving, ready on the filling side stalls the bus via clock stretch
module lcr_buf (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Sync reset
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [lcr_pkg::BUF_WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word held
   input wire logic out_ready, // Consumer takes word
   output logic [lcr_pkg::BUF_WIDTH-1:0] out_data // Word out
);
   typedef struct packed {
      logic [1:0][lcr_pkg::BUF_WIDTH-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } lcr_buf_st_t;
   lcr_buf_st_t st_reg, st_next;

   assign in_ready = st_reg.cnt != 2'(lcr_pkg::BUF_DEPTH);
   assign out_valid = st_reg.cnt != 2'h0;

   always_comb begin
      st_next = st_reg;
      if (in_valid && in_ready) begin
         st_next.mem[st_reg.wp] = in_data;
         st_next.wp = ~st_reg.wp;
      end
      if (out_valid && out_ready) begin
         st_next.rp = ~st_reg.rp;
      end
      st_next.cnt = st_reg.cnt + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      out_data <= st_next.mem[st_next.rp];
   end

   a_buf_no_overfill: assert property (@(posedge sys_clk) disable iff (srst)
      st_reg.cnt <= 2'(lcr_pkg::BUF_DEPTH)) else $error("buffer count above depth");
endmodule

//--- rtl/lcr_rx.sv
// How it works
// - SDA falling with SCL high is start; SDA rising with SCL high is stop.
// - Eight data bits then an acknowledge on the ninth clock; byte count unlimited.
// - Acknowledge drives SDA low across the whole ninth clock high phase.
// - Slave receiver only; SDA is driven solely for acknowledge bits.
// - Address is 011111x; x must equal the address-select pin or transfer ignored.
// - Write only; a read request gets no acknowledge and is ignored.
// - Matching devices acknowledge the address and every command byte.
// - Data bytes are acknowledged only when subaddress counter matches hardware pins.
// - Command bit 7 set means another command follows; clear means data follows.
// - In power saving, SCL is held low until the store buffer has room for the byte.
// - Mode set opcode 10 carries power, enable, bias and drive fields.
// - Drive 01 static, 10 1:2, 11 1:3, 00 1:4 multiplex.
// - Bias 0 third, 1 half; enable 0 blank; power 1 saving.
// - Load data pointer opcode 00 writes a 5-bit pointer, 0..31, with no clamp to 0..23.
// - Device select opcode 1100 loads the 3-bit subaddress counter.
// - Bank select opcode 11110: bit 1 input bank, bit 0 output bank.
// - Bank select is ignored in 1:3 and 1:4 drive modes.
// - Blink opcode 1110: rate field two bits, bit 2 alternate bank blinking.
// - Three hardware subaddress pins form a binary subaddress.
// - Data bytes stored at pointer and subaddress, then the pointer advances.
// - Pointer steps 8 static, 4 at 1:2, 3 at 1:3, 2 at 1:4.
// - Storage only on subaddress match; pointer always steps, overflow bumps counter.
module lcr_rx (
   input wire logic sys_clk, // System clock 10 MHz
   input wire logic srst, // Sync reset, active high
   input wire logic scl_in, // Bus clock pin level
   output logic scl_out, // Always low when driven
   output logic scl_oe, // High while stretching clock
   input wire logic sda_in, // Bus data pin level
   output logic sda_out, // Always low when driven
   output logic sda_oe, // High while acknowledging
   input wire logic addr_select_pin, // Address-select strap
   input wire logic hw_subaddr_bit0, // Hardware subaddress bit 0
   input wire logic hw_subaddr_bit1, // Hardware subaddress bit 1
   input wire logic hw_subaddr_bit2, // Hardware subaddress bit 2
   output logic power_saving_flag, // Power saving mode
   output logic display_enable, // Display enabled
   output logic bias_half, // One-half bias selected
   output logic drive_mode_hi, // Drive mode high bit
   output logic drive_mode_lo, // Drive mode low bit
   output logic input_bank, // Input bank select
   output logic output_bank, // Output bank select
   output logic blink_rate_hi, // Blink rate high bit
   output logic blink_rate_lo, // Blink rate low bit
   output logic blink_alt_bank, // Alternate bank blinking
   output logic [4:0] ram_pointer_field, // Current data pointer
   output logic [2:0] subaddr_count, // Subaddress counter
   output logic wr_valid, // Display byte to store
   input wire logic wr_ready, // RAM store accepts byte
   output logic [4:0] wr_addr, // RAM address of byte
   output logic [7:0] wr_data // Display byte
);
   typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_IGNORE} lcr_phase_t;
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      lcr_phase_t phase;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic ack;
      logic stretch;
      logic lp;
      logic en;
      logic bias;
      logic [1:0] drive;
      logic ibank;
      logic obank;
      logic [1:0] blink;
      logic balt;
      logic [4:0] ptr;
      logic [2:0] sub;
   } lcr_rx_st_t;
   lcr_rx_st_t st_reg, st_next;

   logic [2:0] hw_sub, hw_sub_s;
   logic hw_s1, hw_s2;
   logic buf_ready, buf_in_valid;
   logic [12:0] buf_in;
   logic [12:0] buf_out;
   logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

   function automatic logic [4:0] ptr_step(input logic [1:0] drive);
      case (drive)
         lcr_pkg::DRIVE_STATIC: ptr_step = lcr_pkg::STEP_STATIC;
         lcr_pkg::DRIVE_MUX2: ptr_step = lcr_pkg::STEP_MUX2;
         lcr_pkg::DRIVE_MUX3: ptr_step = lcr_pkg::STEP_MUX3;
         default: ptr_step = lcr_pkg::STEP_MUX4;
      endcase
   endfunction

   assign scl = st_reg.scl_s[1];
   assign sda = st_reg.sda_s[1];
   assign scl_rise = scl && !st_reg.scl_d;
   assign scl_fall = !scl && st_reg.scl_d;
   assign start_c = scl && st_reg.scl_d && !sda && st_reg.sda_d;
   assign stop_c = scl && st_reg.scl_d && sda && !st_reg.sda_d;

   // Straps sampled through two flops like the SCL and SDA pins
   always_ff @(posedge sys_clk) begin
      hw_s1 <= addr_select_pin;
      hw_s2 <= hw_s1;
      hw_sub_s <= {hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
      hw_sub <= hw_sub_s;
   end

   always_comb begin
      logic [7:0] b;
      logic [5:0] sum;
      b = {st_reg.shreg[6:0], sda};
      sum = 6'h00;
      st_next = st_reg;
      st_next.scl_s = {st_reg.scl_s[0], scl_in};
      st_next.sda_s = {st_reg.sda_s[0], sda_in};
      st_next.scl_d = scl;
      st_next.sda_d = sda;
      buf_in_valid = 1'b0;
      buf_in = {st_reg.ptr, st_reg.shreg};
      if (start_c) begin
         st_next.phase = ST_ADDR;
         // The fall closing the start is no bit; it wraps this to zero
         st_next.bitn = '1;
         st_next.ack = 1'b0;
      end else if (stop_c) begin
         st_next.phase = ST_IDLE;
         st_next.ack = 1'b0;
      end else if (st_reg.phase != ST_IDLE && scl_rise && st_reg.bitn <= lcr_pkg::BIT_LAST) begin
         st_next.shreg = b;
      end else if (st_reg.phase != ST_IDLE && scl_fall) begin
         if (st_reg.bitn == lcr_pkg::BIT_LAST) begin
            st_next.bitn = lcr_pkg::BIT_ACK;
            case (st_reg.phase)
               ST_ADDR: begin
                  if (st_reg.shreg[7:2] == lcr_pkg::SLAVE_ADDR_HI
                      && st_reg.shreg[lcr_pkg::ADDR_SEL_BIT] == hw_s2 && !st_reg.shreg[0]) begin
                     st_next.ack = 1'b1;
                  end else begin
                     st_next.phase = ST_IGNORE;
                  end
               end
               ST_CMD: begin
                  st_next.ack = 1'b1;
                  if (st_reg.shreg[6:5] == lcr_pkg::OP_MODE_SET) begin
                     st_next.lp = st_reg.shreg[lcr_pkg::MS_POWER_BIT];
                     st_next.en = st_reg.shreg[lcr_pkg::MS_ENABLE_BIT];
                     st_next.bias = st_reg.shreg[lcr_pkg::MS_BIAS_BIT];
                     st_next.drive = st_reg.shreg[1:0];
                  end else if (st_reg.shreg[6:5] == lcr_pkg::OP_LOAD_PTR) begin
                     st_next.ptr = st_reg.shreg[4:0];
                  end else if (st_reg.shreg[6:3] == lcr_pkg::OP_DEV_SEL) begin
                     st_next.sub = st_reg.shreg[2:0];
                  end else if (st_reg.shreg[6:2] == lcr_pkg::OP_BANK_SEL) begin
                     if (st_reg.drive == lcr_pkg::DRIVE_STATIC || st_reg.drive == lcr_pkg::DRIVE_MUX2) begin
                        st_next.ibank = st_reg.shreg[1];
                        st_next.obank = st_reg.shreg[0];
                     end
                  end else if (st_reg.shreg[6:3] == lcr_pkg::OP_BLINK) begin
                     st_next.balt = st_reg.shreg[2];
                     st_next.blink = st_reg.shreg[1:0];
                  end
               end
               ST_DATA: begin
                  if (st_reg.sub == hw_sub) begin
                     st_next.ack = 1'b1;
                     buf_in_valid = 1'b1;
                     st_next.stretch = !buf_ready;
                  end
                  sum = {1'b0, st_reg.ptr} + {1'b0, ptr_step(st_reg.drive)};
                  if (sum >= {1'b0, lcr_pkg::RAM_WORDS}) begin
                     st_next.ptr = 5'(sum - {1'b0, lcr_pkg::RAM_WORDS});
                     st_next.sub = st_reg.sub + 3'h1;
                  end else begin
                     st_next.ptr = sum[4:0];
                  end
               end
               default: begin
               end
            endcase
         end else if (st_reg.bitn == lcr_pkg::BIT_ACK) begin
            st_next.bitn = 4'h0;
            st_next.ack = 1'b0;
            if (st_reg.phase == ST_ADDR) begin
               st_next.phase = ST_CMD;
            end else if (st_reg.phase == ST_CMD && !st_reg.shreg[lcr_pkg::CONT_BIT]) begin
               st_next.phase = ST_DATA;
            end
         end else begin
            st_next.bitn = st_reg.bitn + 4'h1;
         end
      end
      // Stretch drains once the buffer gives room; the byte is retried then
      if (st_reg.stretch) begin
         buf_in_valid = 1'b1;
         buf_in = {st_reg.ptr, st_reg.shreg};
         if (buf_ready) begin
            st_next.stretch = 1'b0;
         end
      end
      if (!st_reg.lp && !buf_ready) begin
         // Normal mode never stretches; a full buffer drops to keep bus timing
         st_next.stretch = 1'b0;
      end
   end

   // Pointer in stretched retry already advanced; keep the address of the byte
   logic [4:0] held_ptr;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         held_ptr <= 5'h00;
      end else if (buf_in_valid && !st_reg.stretch) begin
         held_ptr <= st_reg.ptr;
      end
   end

   lcr_buf lcr_buf_i (
      .sys_clk(sys_clk),
      .srst(srst),
      .in_valid(buf_in_valid),
      .in_ready(buf_ready),
      .in_data(st_reg.stretch ? {held_ptr, st_reg.shreg} : buf_in),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(buf_out)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.scl_s <= 2'h3;
         st_reg.sda_s <= 2'h3;
         st_reg.scl_d <= 1'b1;
         st_reg.sda_d <= 1'b1;
         st_reg.phase <= ST_IDLE;
         st_reg.drive <= lcr_pkg::RST_DRIVE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = st_reg.ack;
   assign scl_out = 1'b0;
   assign scl_oe = st_reg.stretch && st_reg.lp;
   assign power_saving_flag = st_reg.lp;
   assign display_enable = st_reg.en;
   assign bias_half = st_reg.bias;
   assign drive_mode_hi = st_reg.drive[1];
   assign drive_mode_lo = st_reg.drive[0];
   assign input_bank = st_reg.ibank;
   assign output_bank = st_reg.obank;
   assign blink_rate_hi = st_reg.blink[1];
   assign blink_rate_lo = st_reg.blink[0];
   assign blink_alt_bank = st_reg.balt;
   assign ram_pointer_field = st_reg.ptr;
   assign subaddr_count = st_reg.sub;
   assign wr_addr = buf_out[12:8];
   assign wr_data = buf_out[7:0];

   a_ack_on_ninth: assert property (@(posedge sys_clk) disable iff (srst)
      sda_oe |-> st_reg.bitn == lcr_pkg::BIT_ACK) else $error("ack outside ninth bit");
   a_no_ack_ignored: assert property (@(posedge sys_clk) disable iff (srst)
      st_reg.phase == ST_IGNORE |-> !sda_oe) else $error("ack while ignoring");
   a_start_to_addr: assert property (@(posedge sys_clk) disable iff (srst)
      start_c |=> st_reg.phase == ST_ADDR) else $error("start not seen");
   a_stop_idle: assert property (@(posedge sys_clk) disable iff (srst)
      stop_c |=> st_reg.phase == ST_IDLE && !sda_oe) else $error("stop not seen");
   a_ptr_in_range: assert property (@(posedge sys_clk) disable iff (srst)
      st_reg.phase == ST_DATA |-> st_reg.ptr < lcr_pkg::RAM_WORDS) else $error("pointer out of range");
   a_bank_held_mux: assert property (@(posedge sys_clk) disable iff (srst)
      (st_reg.drive == lcr_pkg::DRIVE_MUX3 || st_reg.drive == lcr_pkg::DRIVE_MUX4) && $stable(st_reg.drive)
      |=> $stable(st_reg.ibank) && $stable(st_reg.obank)) else $error("bank changed in 1:3 or 1:4");
   a_data_ack_match: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(sda_oe) && st_reg.phase == ST_DATA |-> $past(st_reg.sub) == hw_sub) else $error("data ack w/o match");
   a_stretch_lp: assert property (@(posedge sys_clk) disable iff (srst)
      scl_oe |-> power_saving_flag && sda_oe) else $error("stretch outside saving ack");
   sequence s_stretch_room;
      scl_oe && buf_ready;
   endsequence
   sequence s_clock_freed;
      !scl_oe;
   endsequence
   a_stretch_release: assert property (@(posedge sys_clk) disable iff (srst)
      s_stretch_room |=> s_clock_freed) else $error("clock held with room");
endmodule

//--- tb/lcr_master.sv
// Bus master model; SCL only toggles inside frames and idles high
module lcr_master (
   output logic scl_m, // Clock drive, 0 pulls low
   output logic sda_m, // Data drive, 0 pulls low
   input wire logic scl_line, // Resolved clock wire
   input wire logic sda_line // Resolved data wire
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // Stretching slave holds the wire low, so wait for it to really rise
   task automatic clk_hi();
      time t0;
      t0 = $time;
      scl_m = 1'b1;
      wait (scl_line === 1'b1);
      // A stretch ends on a rising system edge; step back off it
      if ($time != t0) #50;
   endtask
   task automatic start();
      sda_m = 1'b1;
      #200 clk_hi();
      #200 sda_m = 1'b0;
      #200 scl_m = 1'b0;
   endtask
   task automatic stop();
      #200 sda_m = 1'b0;
      #200 clk_hi();
      #200 sda_m = 1'b1;
      #400;
   endtask
   // Data moves only while SCL is low
   task automatic bit_io(input logic b, output logic s);
      #200 sda_m = b;
      #200 clk_hi();
      #200 s = sda_line;
      #200 scl_m = 1'b0;
   endtask
   // Eight bits MSB first, then a released ninth bit
   task automatic wr_byte(input logic [7:0] b, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, ack_n);
   endtask
endmodule

//--- tb/lcr_rx_test.sv
module lcr_rx_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic wr_ready = 1'b0;
   logic stall = 1'b0;
   logic sel_pin = 1'b1;
   logic [2:0] hw = 3'h5;
   logic scl_m, sda_m, scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe, wr_valid;
   logic [9:0] cfg;
   logic [4:0] ptr, wr_addr;
   logic [2:0] sub;
   logic [7:0] wr_data;
   logic [12:0] exp_q[$];
   logic [31:0] rng = 32'h0000_0039;
   logic [1:0] drv [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [9:0] e_cfg = 10'h000;
   logic [4:0] e_ptr = 5'h00;
   logic [2:0] e_sub = 3'h0;
   logic seen_stretch = 1'b0;
   int err_total = 0;
   int total_checks = 0;
   always #50 sys_clk = ~sys_clk;
   // Open-drain wires, pulled up when nobody drives low
   assign scl_line = scl_oe ? (scl_out & scl_m) : scl_m;
   assign sda_line = sda_oe ? (sda_out & sda_m) : sda_m;
   lcr_master lcr_master_i (.scl_m(scl_m), .sda_m(sda_m), .scl_line(scl_line), .sda_line(sda_line));
   lcr_rx lcr_rx_i (.sys_clk(sys_clk), .srst(srst), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(sel_pin),
      .hw_subaddr_bit0(hw[0]), .hw_subaddr_bit1(hw[1]), .hw_subaddr_bit2(hw[2]),
      .power_saving_flag(cfg[9]), .display_enable(cfg[8]), .bias_half(cfg[7]), .drive_mode_hi(cfg[6]),
      .drive_mode_lo(cfg[5]), .input_bank(cfg[4]), .output_bank(cfg[3]), .blink_alt_bank(cfg[2]),
      .blink_rate_hi(cfg[1]), .blink_rate_lo(cfg[0]), .ram_pointer_field(ptr), .subaddr_count(sub),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Each store is matched against the oldest noted one; outputs are settled here,
   // and the word goes at the coming rising edge when valid meets the new ready
   always @(negedge sys_clk) begin
      rng <= xs(rng);
      wr_ready <= ~stall & rng[3];
      if (scl_oe === 1'b1) seen_stretch <= 1'b1;
      if (!srst && wr_valid === 1'b1 && !stall && rng[3]) begin
         if (exp_q.size() == 0) check({3'h0, wr_addr, wr_data}, 16'hFFFF);
         else check({3'h0, wr_addr, wr_data}, {3'h0, exp_q.pop_front()});
      end
   end
   task automatic send(input logic [7:0] b, input logic exp_ack_n);
      logic a;
      lcr_master_i.wr_byte(b, a);
      check({15'h0, a}, {15'h0, exp_ack_n});
   endtask
   task automatic open(input logic [7:0] a, input logic exp_ack_n);
      lcr_master_i.start();
      send(a, exp_ack_n);
   endtask
   task automatic close();
      lcr_master_i.stop();
      repeat (20) @(negedge sys_clk);
      check({6'h0, cfg}, {6'h0, e_cfg});
      check({8'h0, ptr, sub}, {8'h0, e_ptr, e_sub});
   endtask
   task automatic cmd(input logic [7:0] c);
      send(c, 1'b0);
      casez (c[6:0])
         7'b10?????: e_cfg[9:5] = c[4:0];
         7'b00?????: e_ptr = c[4:0];
         7'b1100???: e_sub = c[2:0];
         7'b11110??: if (e_cfg[6:5] inside {2'h1, 2'h2}) e_cfg[4:3] = c[1:0];
         7'b1110???: e_cfg[2:0] = c[2:0];
         default: ;
      endcase
   endtask
   task automatic data(input logic [7:0] d);
      logic hit;
      hit = (e_sub == hw);
      if (hit) exp_q.push_back({e_ptr, d});
      send(d, ~hit);
      case (e_cfg[6:5])
         2'h1: e_ptr += 5'h08;
         2'h2: e_ptr += 5'h04;
         2'h3: e_ptr += 5'h03;
         default: e_ptr += 5'h02;
      endcase
      if (e_ptr >= 5'h18) begin
         e_ptr -= 5'h18;
         e_sub++;
      end
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      srst = 1'b0;
      repeat (3) @(negedge sys_clk);
      check({6'h0, cfg}, 16'h0000);
      // Every drive mode; bank bits always flipped so an ignored select shows
      foreach (drv[i]) begin
         open({lcr_pkg::SLAVE_ADDR_HI, sel_pin, 1'b0}, 1'b0);
         cmd({1'b1, 2'b10, 1'b0, rng[1:0], drv[i]});
         cmd({1'b1, 5'b11110, ~e_cfg[4:3]});
         cmd({1'b1, 4'b1110, rng[10:8]});
         cmd({1'b1, 4'b1100, hw});
         cmd({1'b0, 2'b00, 5'h0E});
         repeat (3) data(rng[23:16]);
         close();
      end
      // Mismatched counter, wrap into this device, then a repeated start
      open({lcr_pkg::SLAVE_ADDR_HI, sel_pin, 1'b0}, 1'b0);
      cmd({1'b1, 2'b10, 3'h1, 2'h1});
      cmd({1'b1, 4'b1100, hw - 3'h1});
      cmd({1'b0, 2'b00, 5'h10});
      repeat (2) data(rng[15:8]);
      open({lcr_pkg::SLAVE_ADDR_HI, sel_pin, 1'b0}, 1'b0);
      cmd({1'b0, 2'b00, 5'h00});
      data(rng[15:8]);
      close();
      // Other select level, then a read request: both must be ignored
      open({lcr_pkg::SLAVE_ADDR_HI, ~sel_pin, 1'b0}, 1'b1);
      send(8'hDF, 1'b1);
      close();
      open({lcr_pkg::SLAVE_ADDR_HI, sel_pin, 1'b1}, 1'b1);
      send(8'hDF, 1'b1);
      close();
      check({15'h0, seen_stretch}, 16'h0000);
      // Power saving with the store stalled: the bus must wait, not drop
      open({lcr_pkg::SLAVE_ADDR_HI, sel_pin, 1'b0}, 1'b0);
      cmd({1'b1, 2'b10, 3'h5, 2'h0});
      cmd({1'b1, 4'b1100, hw});
      cmd({1'b0, 2'b00, 5'h00});
      stall = 1'b1;
      fork
         repeat (4) data(rng[15:8]);
         begin
            wait (seen_stretch);
            repeat (200) @(negedge sys_clk);
            stall = 1'b0;
         end
      join
      close();
      check({15'h0, seen_stretch}, 16'h0001);
      check(16'(exp_q.size()), 16'h0000);
      end_of_test();
   end
   initial begin
      #2_000_000;
      err_total++;
      end_of_test();
   end
endmodule
